// >>> inc/trap_unit_regs.vh
`ifndef TRAP_UNIT_REGS_VH
`define TRAP_UNIT_REGS_VH

// Register offsets (byte addresses on the register port)
`define OFS_PSR 8'h00
`define OFS_EPSR 8'h04
`define OFS_BKPT 8'h08
`define OFS_ROOT 8'h0C
`define OFS_FCTL 8'h10
`define OFS_BLEND_LO 8'h14
`define OFS_BLEND_HI 8'h18
`define OFS_LDPIPE_LO 8'h1C
`define OFS_LDPIPE_HI 8'h20
`define OFS_GFX_LO 8'h24
`define OFS_GFX_HI 8'h28

// Status word fields
`define PSR_BRK_RD 0
`define PSR_BRK_WR 1
`define PSR_USER 2
`define PSR_PRIOR_USER 3
`define PSR_IRQ_EN 4
`define PSR_PRIOR_EN 5
`define PSR_IRQ_PEND 6
`define PSR_INSTR_TRAP 7
`define PSR_FETCH_FAULT 8
`define PSR_DATA_FAULT 9
`define PSR_FLOAT_TRAP 10
`define PSR_PMASK_LSB 24
`define PSR_PMASK_MSB 31

// Extended status fields
`define EPSR_TYPE_LSB 0
`define EPSR_TYPE_MSB 7
`define EPSR_STEP_LSB 8
`define EPSR_STEP_MSB 12
`define EPSR_LOCKED 13
`define EPSR_WPROT 14
`define EPSR_TCMODE 15
`define EPSR_BORDER 16
`define EPSR_CSIZE_LSB 20
`define EPSR_CSIZE_MSB 23

// Page-table root fields
`define ROOT_XLATE_EN 0
`define ROOT_DPS_LSB 1
`define ROOT_DPS_MSB 3
`define ROOT_BUS_LOCK 4
`define ROOT_BASE_LSB 12
`define ROOT_BASE_MSB 31

// Float control fields
`define FCTL_FTE 0
`define FCTL_LOAD_SIZE 1
`define FCTL_GFX_PREC 2

// Trap entry point, shared by reset and every other trap
`define TRAP_VECTOR 36'hFFFFFFFF0

// Fixed read-only identity fields (arbitrary values)
`define PROC_TYPE_VAL 8'h5A
`define STEPPING_VAL 5'h03
`define CSIZE_VAL 4'h2

`endif

// >>> logic/load_stage_chain.v
module load_stage_chain #(
  parameter DEPTH = 3,
  parameter W = 64
) (
  input wire clk, // Core clock
  input wire srst, // Synchronous reset
  input wire advance, // One pipelined float load
  input wire [W-1:0] in_data, // Newly loaded value
  input wire in_size, // Width flag of new value
  output wire [W-1:0] out_data, // Oldest value delivered
  output wire out_size // Width flag of oldest value
);
  reg [W-1:0] data_q [0:DEPTH-1];
  reg size_q [0:DEPTH-1];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
      always @(posedge clk) begin
        if (srst) begin
          data_q[i] <= {W{1'b0}};
          size_q[i] <= 1'b0;
        end else if (advance) begin
          data_q[i] <= (i == 0) ? in_data : data_q[(i == 0) ? 0 : i - 1];
          size_q[i] <= (i == 0) ? in_size : size_q[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  // Oldest stage is what the current load hands back (RULE21)
  assign out_data = data_q[DEPTH-1];
  assign out_size = size_q[DEPTH-1];
endmodule

// >>> logic/access_fault_reset_trap_unit.v
// What this block does
// (RULE1) Fetch fault on non-present directory or table
// (RULE2) Fetch fault on supervisor page in user
// (RULE3) Fetch fault locked sequence, accessed flag zero
// (RULE4) Fetch checks only on new group
// (RULE5) Data fault storing to clean page
// (RULE6) Data fault on misaligned operand
// (RULE7) Data fault when breakpoint inside operand
// (RULE8) Data fault on not-present data page
// (RULE9) Data fault on page protection violation
// (RULE10) Data fault locked sequence, accessed zero
// (RULE11) Stale float destination rewritten on resume
// (RULE12) Enabled interrupt sets pending, takes trap
// (RULE13) Reset fetches single-mode from trap vector
// (RULE14) Reset leaves all trap flags clear
// (RULE15) Reset clears user, enable, break, trap flags
// (RULE16) Reset clears extended flags; identity read-only
// (RULE17) Reset clears page size, lock, translate
// (RULE18) Reset invalidates caches, clears modified flags
// (RULE19) Start at supervisor level after reset
// (RULE20) Indirect branch under trap restores user
// (RULE21) Three-stage load pipe, oldest value out
// (RULE22) One-stage graphics pipe plus its state
// (RULE23) Trap entry saves, clears user and enable
// (RULE24) Simultaneous causes set all flags, vector once
//
// Decided for this implementation: the register addresses and strobed register access.
`include "trap_unit_regs.vh"

module access_fault_reset_trap_unit #(
  parameter AW = 8,
  parameter LW = 64
) (
  input wire clk, // Core clock
  input wire srst, // Synchronous reset, active high
  input wire [AW-1:0] reg_addr, // Register byte address
  input wire [31:0] reg_wdata, // Register write data
  input wire reg_wr, // Write strobe
  input wire reg_rd, // Read strobe
  output reg [31:0] reg_rdata, // Read data, cycle after strobe
  input wire fetch_valid, // Fetch translation result valid
  input wire fetch_new_group, // Fetch starts a new group
  input wire fetch_dir_present, // Directory entry present
  input wire fetch_pte_present, // Table entry present
  input wire fetch_super_page, // Page is supervisor-only
  input wire fetch_pte_accessed, // Table entry accessed flag
  input wire dacc_valid, // Data access valid
  input wire dacc_store, // Access is a store
  input wire [31:0] dacc_addr, // Operand address
  input wire [4:0] dacc_len, // Operand length in bytes
  input wire dacc_present, // Data page present
  input wire dacc_super_page, // Data page supervisor-only
  input wire dacc_writable, // Data page writable
  input wire dacc_dirty, // Data page dirty flag
  input wire dacc_accessed, // Data page accessed flag
  input wire next_is_pipe_fp, // Following instr is pipelined float
  input wire ind_branch, // Indirect branch executes
  input wire irq_pin, // External interrupt, asynchronous
  input wire float_load, // Pipelined float load advances
  input wire [LW-1:0] float_load_data, // Value entering load pipe
  input wire float_load_size, // Width of that value
  input wire gfx_issue, // Graphics op enters pipe
  input wire [LW-1:0] gfx_data, // Graphics op result
  output reg trap_take, // One-cycle vector request
  output reg [35:0] redirect_pc, // Fetch target on redirect
  output reg single_mode, // Single-instruction mode
  output reg user_mode, // Current privilege level
  output reg [LW-1:0] load_out, // Oldest load value
  output reg fp_rewrite, // Redo partial float destination
  output reg icache_inval, // Invalidate instruction cache
  output reg tlb_inval, // Invalidate translation buffer
  output reg dcache_mod_clr // Clear data cache modified flags
);
  reg irq_meta_q;
  reg irq_sync_q;

  reg brk_rd_q;
  reg brk_wr_q;
  reg user_q;
  reg prior_user_q;
  reg irq_en_q;
  reg prior_en_q;
  reg irq_pend_q;
  reg instr_trap_q;
  reg fetch_fault_q;
  reg data_fault_q;
  reg float_trap_q;
  reg [7:0] pixel_mask_q;

  reg locked_q;
  reg wprot_q;
  reg tcmode_q;
  reg border_q;

  reg [31:0] bkpt_q;
  reg xlate_en_q;
  reg [2:0] dps_q;
  reg bus_lock_q;
  reg [19:0] root_base_q;

  reg fte_q;
  reg gfx_prec_q;
  reg [LW-1:0] blend_q;
  reg [LW-1:0] gfx_stage_q;
  reg [LW-1:0] gfx_out_q;
  reg stale_fp_q;

  wire [LW-1:0] ld_oldest;
  wire ld_size;

  // Pin is asynchronous; only the second stage is read
  always @(posedge clk) begin
    if (srst) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
    end else begin
      irq_meta_q <= irq_pin;
      irq_sync_q <= irq_meta_q;
    end
  end

  wire wr_psr = reg_wr && (reg_addr == `OFS_PSR);
  wire wr_epsr = reg_wr && (reg_addr == `OFS_EPSR);
  wire wr_bkpt = reg_wr && (reg_addr == `OFS_BKPT);
  wire wr_root = reg_wr && (reg_addr == `OFS_ROOT);
  wire wr_fctl = reg_wr && (reg_addr == `OFS_FCTL);
  wire wr_blo = reg_wr && (reg_addr == `OFS_BLEND_LO);
  wire wr_bhi = reg_wr && (reg_addr == `OFS_BLEND_HI);

  // Fetch checks: prefetched words already in hand are not rechecked
  wire fetch_chk = fetch_valid && fetch_new_group && xlate_en_q; // RULE4
  wire ff_present = !(fetch_dir_present && fetch_pte_present); // RULE1
  wire ff_priv = fetch_super_page && user_q; // RULE2
  wire ff_lock = locked_q && !fetch_pte_accessed; // RULE3
  wire fetch_fault = fetch_chk && (ff_present || ff_priv || ff_lock);

  // Data checks; page checks only with translation on
  wire [31:0] len_m1 = {27'h0, dacc_len} - 32'h00000001;
  wire [32:0] span_end = {1'b0, dacc_addr} + {1'b0, len_m1};
  wire df_align = (dacc_addr & len_m1) != 32'h00000000; // RULE6
  wire bp_hit = ({1'b0, bkpt_q} >= {1'b0, dacc_addr}) && ({1'b0, bkpt_q} <= span_end);
  wire df_bkpt = bp_hit && (dacc_store ? brk_wr_q : brk_rd_q); // RULE7
  wire df_np = xlate_en_q && !dacc_present; // RULE8
  wire df_dirty = xlate_en_q && dacc_store && !dacc_dirty; // RULE5
  wire df_prot = xlate_en_q && ((user_q && dacc_super_page) ||
    (dacc_store && !dacc_writable && (user_q || wprot_q))); // RULE9
  wire df_lock = xlate_en_q && locked_q && !dacc_accessed; // RULE10
  wire data_fault = dacc_valid &&
    (df_align || df_bkpt || df_np || df_dirty || df_prot || df_lock);

  wire irq_take = irq_sync_q && irq_en_q; // RULE12
  wire any_trap = fetch_fault || data_fault || irq_take; // RULE24
  wire trap_pending = instr_trap_q || fetch_fault_q || data_fault_q ||
    float_trap_q || irq_pend_q;
  wire leave_trap = ind_branch && trap_pending && !any_trap;

  // Status word: hardware set wins over a software write of zero
  always @(posedge clk) begin
    if (srst) begin
      brk_rd_q <= 1'b0; // RULE15
      brk_wr_q <= 1'b0;
      user_q <= 1'b0; // RULE19
      prior_user_q <= 1'b0;
      irq_en_q <= 1'b0;
      prior_en_q <= 1'b0;
      irq_pend_q <= 1'b0; // RULE14
      instr_trap_q <= 1'b0;
      fetch_fault_q <= 1'b0;
      data_fault_q <= 1'b0;
      float_trap_q <= 1'b0;
      pixel_mask_q <= 8'h00;
    end else begin
      if (wr_psr) begin
        brk_rd_q <= reg_wdata[`PSR_BRK_RD];
        brk_wr_q <= reg_wdata[`PSR_BRK_WR];
        pixel_mask_q <= reg_wdata[`PSR_PMASK_MSB:`PSR_PMASK_LSB];
        instr_trap_q <= reg_wdata[`PSR_INSTR_TRAP];
        float_trap_q <= reg_wdata[`PSR_FLOAT_TRAP];
      end
      irq_pend_q <= (wr_psr ? reg_wdata[`PSR_IRQ_PEND] : irq_pend_q) || irq_take;
      fetch_fault_q <= (wr_psr ? reg_wdata[`PSR_FETCH_FAULT] : fetch_fault_q) ||
        fetch_fault; // RULE24
      data_fault_q <= (wr_psr ? reg_wdata[`PSR_DATA_FAULT] : data_fault_q) ||
        data_fault;
      if (any_trap) begin
        prior_user_q <= user_q; // RULE23
        prior_en_q <= irq_en_q;
        user_q <= 1'b0;
        irq_en_q <= 1'b0;
      end else if (wr_psr) begin
        user_q <= reg_wdata[`PSR_USER];
        prior_user_q <= reg_wdata[`PSR_PRIOR_USER];
        irq_en_q <= reg_wdata[`PSR_IRQ_EN];
        prior_en_q <= reg_wdata[`PSR_PRIOR_EN];
      end else if (ind_branch && trap_pending) begin
        user_q <= prior_user_q; // RULE20
      end
    end
  end

  // Extended status, breakpoint, root and float control
  always @(posedge clk) begin
    if (srst) begin
      locked_q <= 1'b0; // RULE16
      wprot_q <= 1'b0;
      tcmode_q <= 1'b0;
      border_q <= 1'b0;
      bkpt_q <= 32'h00000000;
      xlate_en_q <= 1'b0; // RULE17
      dps_q <= 3'h0;
      bus_lock_q <= 1'b0;
      root_base_q <= 20'h00000;
      fte_q <= 1'b0;
      gfx_prec_q <= 1'b0;
    end else begin
      if (wr_epsr) begin
        locked_q <= reg_wdata[`EPSR_LOCKED];
        wprot_q <= reg_wdata[`EPSR_WPROT];
        tcmode_q <= reg_wdata[`EPSR_TCMODE];
        border_q <= reg_wdata[`EPSR_BORDER];
      end
      if (wr_bkpt) begin
        bkpt_q <= reg_wdata;
      end
      if (wr_root) begin
        xlate_en_q <= reg_wdata[`ROOT_XLATE_EN];
        dps_q <= reg_wdata[`ROOT_DPS_MSB:`ROOT_DPS_LSB];
        bus_lock_q <= reg_wdata[`ROOT_BUS_LOCK];
        root_base_q <= reg_wdata[`ROOT_BASE_MSB:`ROOT_BASE_LSB];
      end
      if (wr_fctl) begin
        fte_q <= reg_wdata[`FCTL_FTE];
        gfx_prec_q <= reg_wdata[`FCTL_GFX_PREC];
      end
    end
  end

  // Graphics pipe: one stage, result appears on the next issue
  always @(posedge clk) begin
    if (srst) begin
      gfx_stage_q <= {LW{1'b0}};
      gfx_out_q <= {LW{1'b0}};
      blend_q <= {LW{1'b0}};
    end else begin
      if (gfx_issue) begin
        gfx_stage_q <= gfx_data; // RULE22
        gfx_out_q <= gfx_stage_q;
      end
      if (wr_blo) begin
        blend_q[31:0] <= reg_wdata;
      end
      if (wr_bhi) begin
        blend_q[LW-1:32] <= reg_wdata;
      end
    end
  end

  load_stage_chain #(
    .DEPTH(3),
    .W(LW)
  ) u_load_pipe (
    .clk(clk),
    .srst(srst),
    .advance(float_load), // RULE21
    .in_data(float_load_data),
    .in_size(float_load_size),
    .out_data(ld_oldest),
    .out_size(ld_size)
  );

  // Partial float destination is remembered until the resuming branch
  always @(posedge clk) begin
    if (srst) begin
      stale_fp_q <= 1'b0;
      fp_rewrite <= 1'b0;
    end else begin
      fp_rewrite <= leave_trap && stale_fp_q; // RULE11
      if (data_fault && next_is_pipe_fp) begin
        stale_fp_q <= 1'b1;
      end else if (leave_trap) begin
        stale_fp_q <= 1'b0;
      end
    end
  end

  // Redirect: reset and every trap share the vector
  always @(posedge clk) begin
    if (srst) begin
      trap_take <= 1'b1; // RULE13
      redirect_pc <= `TRAP_VECTOR;
      single_mode <= 1'b1;
      user_mode <= 1'b0;
      load_out <= {LW{1'b0}};
      icache_inval <= 1'b1; // RULE18
      tlb_inval <= 1'b1;
      dcache_mod_clr <= 1'b1;
    end else begin
      trap_take <= any_trap; // RULE24
      if (any_trap) begin
        redirect_pc <= `TRAP_VECTOR;
        single_mode <= 1'b1;
      end else if (wr_psr) begin
        single_mode <= 1'b0;
      end
      user_mode <= any_trap ? 1'b0 : user_q;
      load_out <= ld_oldest;
      icache_inval <= 1'b0;
      tlb_inval <= 1'b0;
      dcache_mod_clr <= 1'b0;
    end
  end

  // Read port: data one cycle after strobe; unmapped reads zero
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_PSR: begin
          reg_rdata <= {pixel_mask_q, 13'h0, float_trap_q, data_fault_q,
            fetch_fault_q, instr_trap_q, irq_pend_q, prior_en_q, irq_en_q,
            prior_user_q, user_q, brk_wr_q, brk_rd_q};
        end
        `OFS_EPSR: begin
          reg_rdata <= {8'h00, `CSIZE_VAL, 3'h0, border_q, tcmode_q, wprot_q,
            locked_q, `STEPPING_VAL, `PROC_TYPE_VAL}; // RULE16
        end
        `OFS_BKPT: begin
          reg_rdata <= bkpt_q;
        end
        `OFS_ROOT: begin
          reg_rdata <= {root_base_q, 7'h00, bus_lock_q, dps_q, xlate_en_q};
        end
        `OFS_FCTL: begin
          reg_rdata <= {29'h0, gfx_prec_q, ld_size, fte_q}; // RULE21
        end
        `OFS_BLEND_LO: begin
          reg_rdata <= blend_q[31:0];
        end
        `OFS_BLEND_HI: begin
          reg_rdata <= blend_q[LW-1:32];
        end
        `OFS_LDPIPE_LO: begin
          reg_rdata <= ld_oldest[31:0];
        end
        `OFS_LDPIPE_HI: begin
          reg_rdata <= ld_oldest[LW-1:32];
        end
        `OFS_GFX_LO: begin
          reg_rdata <= gfx_out_q[31:0];
        end
        `OFS_GFX_HI: begin
          reg_rdata <= gfx_out_q[LW-1:32];
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end
endmodule

// >>> dv/trap_unit_checker.sv
module trap_unit_checker #(
  parameter AW = 8
) (
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic [AW-1:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic fetch_valid, // Fetch
  input wire logic fetch_new_group, // New group
  input wire logic fetch_dir_present, // Dir present
  input wire logic fetch_super_page, // Super page
  input wire logic dacc_valid, // Data access
  input wire logic dacc_store, // Store
  input wire logic [31:0] dacc_addr, // Operand
  input wire logic [4:0] dacc_len, // Length
  input wire logic dacc_dirty, // Dirty
  input wire logic irq_pin, // Interrupt
  input wire logic trap_take, // Vector
  input wire logic [35:0] redirect_pc, // Target
  input wire logic single_mode, // Single
  input wire logic user_mode, // User
  input wire logic icache_inval, // Inval
  input wire logic tlb_inval, // Inval
  input wire logic dcache_mod_clr // Clear
);
  logic xl_q;
  logic en_q;
  // Enable copy lags the design by a cycle on traps; the trap itself covers that gap
  always @(posedge clk) begin
    if (srst) begin
      xl_q <= 1'b0;
      en_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 8'h0C)
        xl_q <= reg_wdata[0];
      if (trap_take)
        en_q <= 1'b0;
      else if (reg_wr && reg_addr == 8'h00)
        en_q <= reg_wdata[4];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_rel;
    srst ##1 !srst;
  endsequence
  sequence s_irq;
    (en_q && irq_pin) [*3];
  endsequence
  property p_rst;
    disable iff (1'b0) srst |=> trap_take && single_mode && !user_mode;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_inv;
    disable iff (1'b0) srst |=> icache_inval && tlb_inval && dcache_mod_clr;
  endproperty
  a_inv: assert property (p_inv) else $error("invalidate missing");
  property p_inv_drop;
    disable iff (1'b0) s_rel |=> !(icache_inval || tlb_inval || dcache_mod_clr);
  endproperty
  a_inv_drop: assert property (p_inv_drop) else $error("invalidate stuck");
  property p_entry;
    trap_take |-> !user_mode && single_mode && redirect_pc == 36'hFFFFFFFF0;
  endproperty
  a_entry: assert property (p_entry) else $error("trap entry wrong");
  property p_mis;
    dacc_valid && dacc_len == 5'h04 && dacc_addr[1:0] != 2'h0 |=> trap_take;
  endproperty
  a_mis: assert property (p_mis) else $error("misalign missed");
  property p_fnp;
    fetch_valid && fetch_new_group && xl_q && !fetch_dir_present |=> trap_take;
  endproperty
  a_fnp: assert property (p_fnp) else $error("fetch absent missed");
  property p_fsup;
    fetch_valid && fetch_new_group && xl_q && fetch_super_page |=> trap_take || !user_mode;
  endproperty
  a_fsup: assert property (p_fsup) else $error("fetch super missed");
  property p_st;
    dacc_valid && dacc_store && xl_q && !dacc_dirty |=> trap_take;
  endproperty
  a_st: assert property (p_st) else $error("clean store missed");
  property p_irq;
    s_irq |-> ##[0:2] trap_take;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missed");
endmodule

bind access_fault_reset_trap_unit trap_unit_checker #(.AW(AW)) chk (
  .clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .fetch_valid, .fetch_new_group,
  .fetch_dir_present, .fetch_super_page, .dacc_valid, .dacc_store, .dacc_addr,
  .dacc_len, .dacc_dirty, .irq_pin, .trap_take, .redirect_pc, .single_mode,
  .user_mode, .icache_inval, .tlb_inval, .dcache_mod_clr
);

// >>> dv/ext_irq_source.sv
module ext_irq_source (
  input wire logic clk, // Bench clock
  input wire logic raise, // Assert request
  input wire logic drop, // Release request
  input wire logic [7:0] lag, // Delay in ns
  output logic irq_pin // Interrupt level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Delay keeps the edge off the clock so the synchroniser sees real skew
  initial irq_pin = 1'b0;
  always @(posedge clk) begin
    if (raise)
      irq_pin <= #(lag) 1'b1;
    if (drop)
      irq_pin <= #(lag) 1'b0;
  end
endmodule

// >>> dv/access_fault_reset_trap_unit_test.sv
`include "trap_unit_regs.vh"
module access_fault_reset_trap_unit_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] GOOD = 14'h0D2E;
  localparam logic [13:0] MASK [12] = '{14'h3800, 14'h3400, 14'h3200, 14'h3100, 14'h2200,
    14'h00C4, 14'h0080, 14'h0080, 14'h00A1, 14'h0090, 14'h0082, 14'h3880};
  localparam logic [31:0] ID = {8'h00, `CSIZE_VAL, 7'h00, `STEPPING_VAL, `PROC_TYPE_VAL};
  localparam logic [31:0] ALL = 32'hFFFFFFFF;
  logic clk, srst, reg_wr, reg_rd, ind_branch, float_load, float_load_size, gfx_issue;
  logic raise, drop, seen;
  logic [7:0] reg_addr, lag;
  logic [31:0] reg_wdata, dacc_addr;
  logic [4:0] dacc_len;
  logic [63:0] float_load_data, gfx_data, va, vb;
  logic [13:0] st;
  logic [63:0] q[$];
  wire fetch_valid, fetch_new_group, fetch_dir_present, fetch_pte_present, fetch_super_page;
  wire fetch_pte_accessed, dacc_valid, dacc_store, dacc_present, dacc_super_page;
  wire dacc_writable, dacc_dirty, dacc_accessed, next_is_pipe_fp, irq_pin;
  wire [31:0] reg_rdata;
  wire [35:0] redirect_pc;
  wire [63:0] load_out;
  wire trap_take, single_mode, user_mode, fp_rewrite, icache_inval, tlb_inval, dcache_mod_clr;
  int errors, comparisons, cyc, u_m, pu_m, en_m, pen_m, fl_m, f, u, i, k;
  assign {fetch_valid, fetch_new_group, fetch_dir_present, fetch_pte_present, fetch_super_page,
    fetch_pte_accessed, dacc_valid, dacc_store, dacc_present, dacc_super_page, dacc_writable,
    dacc_dirty, dacc_accessed, next_is_pipe_fp} = st;
  access_fault_reset_trap_unit uut (
    .clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .fetch_valid,
    .fetch_new_group, .fetch_dir_present, .fetch_pte_present, .fetch_super_page,
    .fetch_pte_accessed, .dacc_valid, .dacc_store, .dacc_addr, .dacc_len, .dacc_present,
    .dacc_super_page, .dacc_writable, .dacc_dirty, .dacc_accessed, .next_is_pipe_fp,
    .ind_branch, .irq_pin, .float_load, .float_load_data, .float_load_size, .gfx_issue,
    .gfx_data, .trap_take, .redirect_pc, .single_mode, .user_mode, .load_out, .fp_rewrite,
    .icache_inval, .tlb_inval, .dcache_mod_clr
  );
  ext_irq_source irq_src (.clk, .raise, .drop, .lag, .irq_pin);
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e, m);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(n, e, reg_rdata & m);
  endtask
  function automatic logic [31:0] psr_m();
    return fl_m | 1 | (u_m << 2) | (pu_m << 3) | (en_m << 4) | (pen_m << 5);
  endfunction
  task automatic wpsr(input int p, input int e);
    wr(`OFS_PSR, 32'h81 | (p << 3) | (e << 4));
    fl_m = 32'h80;
    u_m = 0;
    pu_m = p;
    en_m = e;
    pen_m = 0;
  endtask
  task automatic trap_m(input int fl);
    pu_m = u_m;
    pen_m = en_m;
    u_m = 0;
    en_m = 0;
    fl_m |= fl;
  endtask
  task automatic branch(input logic fp);
    @(posedge clk);
    ind_branch <= 1'b1;
    @(posedge clk);
    ind_branch <= 1'b0;
    u_m = pu_m;
    @(negedge clk);
    chk("fp_rewrite", fp, fp_rewrite);
    @(negedge clk);
    chk("user_mode", u_m[0], user_mode);
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {reg_wr, reg_rd, ind_branch, float_load, float_load_size, gfx_issue, raise, drop} = 8'h00;
    {reg_addr, reg_wdata, float_load_data, gfx_data, lag} = '0;
    st = GOOD;
    dacc_addr = 32'h00002000;
    dacc_len = 5'h04;
    k = $urandom(24);
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk("trap_take", 1'b1, trap_take);
    chk("redirect_pc", `TRAP_VECTOR, redirect_pc);
    chk("single_mode", 1'b1, single_mode);
    chk("user_mode", 1'b0, user_mode);
    chk("inval", 3'h7, {icache_inval, tlb_inval, dcache_mod_clr});
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("inval", 3'h0, {icache_inval, tlb_inval, dcache_mod_clr});
    rdc("psr", `OFS_PSR, 32'h0, 32'h000007FF);
    rdc("epsr", `OFS_EPSR, ID, 32'h00F1FFFF);
    rdc("root", `OFS_ROOT, 32'h0, 32'h0000001F);
    rdc("unmapped", 8'h40, 32'h0, ALL);
    wr(`OFS_EPSR, 32'h000020FF);
    rdc("epsr", `OFS_EPSR, ID | 32'h00002000, 32'h00F1FFFF);
    wr(`OFS_ROOT, 32'h00000001);
    wr(`OFS_BKPT, 32'h00001004);
    for (k = 0; k < 12; k++) begin
      u = (k == 2 || k == 4 || k == 9);
      f = k < 4 ? 32'h100 : k == 4 ? 0 : k == 11 ? 32'h300 : 32'h200;
      wpsr(u, 0);
      branch(1'b0);
      @(posedge clk);
      st <= GOOD ^ MASK[k];
      dacc_addr <= k == 7 ? 32'h00001000 : 32'h00002000 + (k == 6 || k == 11) *
        (32'h00001000 + $urandom_range(3, 1));
      dacc_len <= k == 7 ? 5'h08 : 5'h04;
      @(posedge clk);
      st <= GOOD;
      @(negedge clk);
      chk("trap_take", f != 0, trap_take);
      if (f != 0)
        trap_m(f);
      chk("user_mode", u_m[0], user_mode);
      rdc("psr", `OFS_PSR, psr_m(), ALL);
      branch(k == 8);
    end
    for (k = 0; k < 3; k++) begin
      wpsr(0, k < 2);
      lag <= k == 1 ? 8'h1F : 8'h03;
      raise <= 1'b1;
      @(posedge clk);
      raise <= 1'b0;
      seen = 1'b0;
      repeat (8) begin
        @(negedge clk);
        seen |= trap_take;
      end
      chk("irq trap", k < 2, seen);
      if (k < 2)
        trap_m(32'h40);
      rdc("psr", `OFS_PSR, psr_m(), ALL);
      @(posedge clk);
      drop <= 1'b1;
      @(posedge clk);
      drop <= 1'b0;
      repeat (4) @(posedge clk);
    end
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      va = {$urandom, $urandom};
      float_load <= 1'b1;
      float_load_data <= va;
      float_load_size <= va[0];
      q.push_back(va);
      @(posedge clk);
      float_load <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      if (q.size() > 2) begin
        vb = q.pop_front();
        chk("load_out", vb, load_out);
      end
    end
    rdc("ldpipe lo", `OFS_LDPIPE_LO, vb[31:0], ALL);
    wr(`OFS_FCTL, 32'h00000007);
    rdc("fctl", `OFS_FCTL, 32'h5 | (vb[0] << 1), ALL);
    vb = {$urandom, $urandom};
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      gfx_issue <= 1'b1;
      gfx_data <= i ? vb : va;
      @(posedge clk);
      gfx_issue <= 1'b0;
    end
    rdc("gfx lo", `OFS_GFX_LO, va[31:0], ALL);
    rdc("gfx hi", `OFS_GFX_HI, va[63:32], ALL);
    wr(`OFS_BLEND_LO, vb[31:0]);
    wr(`OFS_BLEND_HI, vb[63:32]);
    rdc("blend lo", `OFS_BLEND_LO, vb[31:0], ALL);
    rdc("blend hi", `OFS_BLEND_HI, vb[63:32], ALL);
    complete_run();
  end
endmodule
